// *** core/tlb_map.vh ***
// Offsets, field positions, reset values and widths of the translation
// buffer and its small register block.
// Assumes it is included once per compilation unit by its bare name.
`ifndef TLB_MAP_VH
`define TLB_MAP_VH

// Array geometry.
`define TLB_TAG_W 41
`define TLB_DATA_W 28
`define TLB_IDX_W 5
`define TLB_ENTRIES 32

// Layout of one tag word and of the compare data.
`define TLB_VALID_BIT 40
`define TLB_MOD_BIT 39
`define TLB_PERM_HI 38
`define TLB_PERM_LO 33
`define TLB_LVL_HI 32
`define TLB_LVL_LO 30
`define TLB_REGION_W 10
`define TLB_REGIONS 3
`define TLB_LVL_ALL 3'h7

// Bit positions inside the six-bit permission field.
`define TLB_PERM_W 6
`define TLB_USER_EXECUTE_PERM 5
`define TLB_USER_READ_PERM 4
`define TLB_USER_WRITE_PERM 3
`define TLB_SUPER_EXECUTE_PERM 2
`define TLB_SUPER_READ_PERM 1
`define TLB_SUPER_WRITE_PERM 0

// Register byte offsets on the register bus.
`define TLB_ADR_W 4
`define TLB_REG_IRQ_STAT 4'h0
`define TLB_REG_IRQ_MASK 4'h4
`define TLB_REG_STATE 4'h8

// Event bits, shared by the status and mask registers.
`define TLB_EV_W 4
`define TLB_EV_MISS 0
`define TLB_EV_ERR 1
`define TLB_EV_FLUSH 2
`define TLB_EV_MULTI 3
`define TLB_IRQ_MASK_RST 4'h0
`define TLB_STATE_W 8

`endif

// *** core/tlb_wb_regs.v ***
// Wishbone classic slave holding the event status, mask and state view.
// Assumes a single clock shared with the translation buffer core.
`timescale 1ns/1ps
`include "tlb_map.vh"

module tlb_wb_regs (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`TLB_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [`TLB_EV_W-1:0] event_i,
  input wire [`TLB_STATE_W-1:0] state_i,
  output wire irq_o
);

  reg ack_q;
  reg [`TLB_EV_W-1:0] stat_q;
  reg [`TLB_EV_W-1:0] stat_d;
  reg [`TLB_EV_W-1:0] mask_q;
  reg [31:0] rdata_d;
  wire req;
  wire wr_now;
  wire [`TLB_ADR_W-1:0] word_adr;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake.

  // Every access is answered one cycle after it is presented; the ack
  // drops in the next cycle so back to back requests see a gap.
  assign req = wb_cyc_i & wb_stb_i;
  assign wb_ack_o = ack_q;
  assign word_adr = {wb_adr_i[`TLB_ADR_W-1:2], 2'b00};
  // A write lands on the edge where the master sees ack, not earlier.
  assign wr_now = req & wb_we_i & ack_q & wb_sel_i[0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read data is latched with the ack and unmapped words read as zero.
  always @* begin
    rdata_d = 32'h0000_0000;
    case (word_adr)
      `TLB_REG_IRQ_STAT: rdata_d[`TLB_EV_W-1:0] = stat_q;
      `TLB_REG_IRQ_MASK: rdata_d[`TLB_EV_W-1:0] = mask_q;
      `TLB_REG_STATE: rdata_d[`TLB_STATE_W-1:0] = state_i;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~ack_q) begin
      wb_dat_o <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status and mask.

  // A fresh event beats a write-one-to-clear in the same cycle, so an
  // event is never lost to a clear that raced it.
  always @* begin
    stat_d = stat_q;
    if (wr_now && word_adr == `TLB_REG_IRQ_STAT) begin
      stat_d = stat_q & ~wb_dat_i[`TLB_EV_W-1:0];
    end
    stat_d = stat_d | event_i;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= {`TLB_EV_W{1'b0}};
      mask_q <= `TLB_IRQ_MASK_RST;
    end else begin
      stat_q <= stat_d;
      if (wr_now && word_adr == `TLB_REG_IRQ_MASK) begin
        mask_q <= wb_dat_i[`TLB_EV_W-1:0];
      end
    end
  end

  assign irq_o = |(stat_q & mask_q); // Level, high while unmasked bit set.

endmodule // tlb_wb_regs

// *** core/tlb_cam_sram.v ***
// Fully associative translation buffer: tag CAM and data SRAM addressed
// as one unit, with compare, direct read, direct write and flush.
// Assumes the translation controller runs on clk_i and drives every
// operation input from its own registers, so no synchroniser is needed.
//
// What this block and its controller do
// R1: Flush and compare enable captured together start a flush next cycle.
// R2: A flush clears the valid bit of every entry whose tag matches.
// R3: A flush touches only valid bits; other tag bits and data stay.
// R4: Level mask all ones makes every entry match, clearing every valid bit.
// R5: The controller ignores miss while a flush is running.
// R6: Direct read: index 00-1F selects the entry whose tag and data appear.
// R7: Compare read: the match lines select the entry, the index is ignored.
// R8: Direct write: index, enables, tag and data all pass input registers.
// R9: Separate tag and data write enables with the same registered timing.
// R10: The controller gives the write index one cycle before data and enables.
// R11: Flush criteria arrive like a compare; source and write enables stay low.
// R12: Registered select source picks match lines (low) or decoded index (high).
// R13: A compare raises a match line per hit entry and miss when none hit.
// R14: Error is high for a valid hit lacking a requested permission bit.
// R15: Access permitted needs no miss, no error and a suitable modified bit.
// R16: A flush with no matching entry changes no entry and raises no event; miss_o still goes high.
// R17: The controller never asserts flush and a write enable together.
`timescale 1ns/1ps
`include "tlb_map.vh"

module tlb_cam_sram #(
  parameter ENTRIES = `TLB_ENTRIES,
  parameter IDX_W = `TLB_IDX_W
) (
  input wire clk_i,
  input wire rst_i,
  input wire [`TLB_TAG_W-1:0] compare_data_in_i,
  input wire [`TLB_DATA_W-1:0] translation_data_in_i,
  input wire [IDX_W-1:0] entry_index_i,
  input wire select_source_i,
  input wire compare_en_i,
  input wire flush_i,
  input wire tag_we_i,
  input wire data_we_i,
  input wire aux_control_r_i,
  input wire [`TLB_PERM_W-1:0] req_perm_i,
  output reg [`TLB_TAG_W-1:0] tag_data_out_o,
  output reg [`TLB_DATA_W-1:0] translation_data_out_o,
  output reg miss_o,
  output reg error_o,
  output reg access_permitted_o,
  output reg modified_miss_o,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`TLB_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire irq_o
);

  // Storage. Reset leaves both arrays alone; only the input registers and
  // the output registers, flags and data words alike, take defined values.
  reg [`TLB_TAG_W-1:0] tag_mem [0:ENTRIES-1];
  reg [`TLB_DATA_W-1:0] dat_mem [0:ENTRIES-1];

  // Registered operation inputs.
  reg [`TLB_TAG_W-1:0] cd_q;
  reg [`TLB_DATA_W-1:0] rd_q;
  reg [IDX_W-1:0] idx_q;
  reg [IDX_W-1:0] widx_q;
  reg src_q;
  reg cen_q;
  reg flush_q;
  reg twe_q;
  reg dwe_q;
  reg aux_q;
  reg [`TLB_PERM_W-1:0] perm_q;

  // Per-entry select lines.
  wire [ENTRIES-1:0] tag_eq;
  wire [ENTRIES-1:0] cmp_hit;
  wire [ENTRIES-1:0] dir_sel;
  wire [ENTRIES-1:0] wr_sel;
  wire [ENTRIES-1:0] word_sel;

  wire do_flush;
  wire do_cmp;
  wire do_write;
  wire any_hit;
  wire multi_hit;

  reg [`TLB_TAG_W-1:0] tag_rd;
  reg [`TLB_DATA_W-1:0] dat_rd;
  reg [5:0] valid_cnt;
  reg err_d;
  reg mok_d;
  integer k;

  ////////////////////////////////////////////////////////////////////////////
  // Tag compare function.

  // Each set bit of the level mask turns one tag region into a don't care,
  // so coarser flushes simply set more mask bits.
  function tag_match;
    input [`TLB_TAG_W-1:0] stored;
    input [`TLB_TAG_W-1:0] crit;
    integer r;
    reg hit;
    begin
      hit = 1'b1;
      for (r = 0; r < `TLB_REGIONS; r = r + 1) begin
        if (!crit[`TLB_LVL_LO+r] &&
            stored[r*`TLB_REGION_W +: `TLB_REGION_W] !=
            crit[r*`TLB_REGION_W +: `TLB_REGION_W]) begin
          hit = 1'b0;
        end
      end
      tag_match = hit;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input registers.

  // Everything the controller drives is captured here; the operation
  // itself happens in the cycle after the capture edge. The write index
  // takes one more stage, so a write uses the index given one cycle ahead
  // of its data and enables.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cd_q <= {`TLB_TAG_W{1'b0}};
      rd_q <= {`TLB_DATA_W{1'b0}};
      idx_q <= {IDX_W{1'b0}};
      widx_q <= {IDX_W{1'b0}};
      src_q <= 1'b0;
      cen_q <= 1'b0;
      flush_q <= 1'b0;
      twe_q <= 1'b0;
      dwe_q <= 1'b0;
      aux_q <= 1'b0;
      perm_q <= {`TLB_PERM_W{1'b0}};
    end else begin
      cd_q <= compare_data_in_i; // [R8]
      rd_q <= translation_data_in_i; // [R8]
      idx_q <= entry_index_i;
      widx_q <= idx_q; // [R10]
      src_q <= select_source_i; // [R12]
      cen_q <= compare_en_i;
      flush_q <= flush_i; // [R1]
      twe_q <= tag_we_i; // [R9]
      dwe_q <= data_we_i; // [R9]
      aux_q <= aux_control_r_i;
      perm_q <= req_perm_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode.

  // The auxiliary control must be low for a flush, compare or write. A flush wins over
  // a write enable given in the same cycle, since that pairing has no
  // defined meaning and losing the write is safer than corrupting an entry.
  assign do_flush = flush_q & cen_q & ~src_q & ~aux_q; // [R1] [R11]
  assign do_cmp = cen_q & ~src_q & ~flush_q & ~aux_q; // [R7]
  assign do_write = (twe_q | dwe_q) & src_q & ~flush_q & ~aux_q; // [R8] [R17]

  ////////////////////////////////////////////////////////////////////////////
  // Entries.

  // One slice per entry: its compare, its decoded index lines and its
  // update. Flush matching ignores the stored valid bit so that a flush
  // of all entries also cleans entries never written since power up.
  genvar i;
  generate
    for (i = 0; i < ENTRIES; i = i + 1) begin : g_entry
      assign tag_eq[i] = tag_match(tag_mem[i], cd_q); // [R4]
      assign cmp_hit[i] = tag_eq[i] & tag_mem[i][`TLB_VALID_BIT]; // [R13]
      assign dir_sel[i] = (idx_q == i); // [R6]
      assign wr_sel[i] = (widx_q == i);

      always @(posedge clk_i) begin
        if (do_flush) begin
          if (tag_eq[i]) begin
            tag_mem[i][`TLB_VALID_BIT] <= 1'b0; // [R2] [R3] [R16]
          end
        end else if (do_write && wr_sel[i]) begin
          if (twe_q) begin
            tag_mem[i] <= cd_q; // [R9]
          end
          if (dwe_q) begin
            dat_mem[i] <= rd_q; // [R9]
          end
        end
      end
    end
  endgenerate

  // Registered source picks decoded index or match lines.
  assign word_sel = src_q ? dir_sel : cmp_hit; // [R12]
  assign any_hit = |cmp_hit;
  assign multi_hit = |(cmp_hit & (cmp_hit - 1'b1));

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  // Selected words are ORed together. With several hits the result is a
  // blend that callers must not trust; with none it reads as zero.
  always @* begin
    tag_rd = {`TLB_TAG_W{1'b0}};
    dat_rd = {`TLB_DATA_W{1'b0}};
    valid_cnt = 6'h00;
    for (k = 0; k < ENTRIES; k = k + 1) begin
      if (word_sel[k]) begin
        tag_rd = tag_rd | tag_mem[k]; // [R6] [R7]
        dat_rd = dat_rd | dat_mem[k];
      end
      valid_cnt = valid_cnt + {5'h00, tag_mem[k][`TLB_VALID_BIT]};
    end
  end

  // Protection check against the hit entry's stored permissions.
  always @* begin
    err_d = do_cmp & any_hit & tag_rd[`TLB_VALID_BIT] &
      (|(~tag_rd[`TLB_PERM_HI:`TLB_PERM_LO] & perm_q)); // [R14]
    mok_d = tag_rd[`TLB_MOD_BIT] | ~(perm_q[`TLB_USER_WRITE_PERM] |
      perm_q[`TLB_SUPER_WRITE_PERM]); // [R15]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers.

  // Outputs reflect the operation of the previous cycle. A write falls
  // through: the enabled parts show the new word in the cycle after it.
  always @(posedge clk_i) begin
    if (rst_i) begin
      tag_data_out_o <= {`TLB_TAG_W{1'b0}};
      translation_data_out_o <= {`TLB_DATA_W{1'b0}};
      miss_o <= 1'b0;
      error_o <= 1'b0;
      access_permitted_o <= 1'b0;
      modified_miss_o <= 1'b0;
    end else begin
      tag_data_out_o <= (do_write & twe_q) ? cd_q : tag_rd;
      translation_data_out_o <= (do_write & dwe_q) ? rd_q : dat_rd;
      // Miss is shown on flushes too; the controller disregards it there.
      miss_o <= (do_cmp | do_flush) & ~any_hit; // [R13] [R5]
      error_o <= err_d; // [R14]
      access_permitted_o <= do_cmp & any_hit & ~err_d & mok_d; // [R15]
      modified_miss_o <= do_cmp & (~any_hit | ~mok_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register block and interrupt.

  // Events pulse for one cycle during the operation cycle. A miss during
  // a flush is not an event, matching how the controller treats it.
  wire [`TLB_EV_W-1:0] events;
  assign events[`TLB_EV_MISS] = do_cmp & ~any_hit; // [R5]
  assign events[`TLB_EV_ERR] = err_d;
  assign events[`TLB_EV_FLUSH] = do_flush & (|tag_eq);
  assign events[`TLB_EV_MULTI] = do_cmp & multi_hit;

  tlb_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .event_i(events),
    .state_i({error_o, miss_o, valid_cnt}),
    .irq_o(irq_o)
  );

endmodule // tlb_cam_sram

// *** sim/tlb_cam_sram_props.sv ***
// Checker for the translation buffer's operation and register ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "tlb_map.vh"
module tlb_cam_sram_props (
  input wire clk_i,
  input wire rst_i,
  input wire [`TLB_TAG_W-1:0] compare_data_in_i,
  input wire select_source_i,
  input wire compare_en_i,
  input wire flush_i,
  input wire tag_we_i,
  input wire aux_control_r_i,
  input wire [`TLB_TAG_W-1:0] tag_data_out_o,
  input wire miss_o,
  input wire error_o,
  input wire access_permitted_o,
  input wire modified_miss_o,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////
  // Operation shapes at the capture edge; the outputs are registered at the
  // next edge, so they are sampled two edges after the capture.
  sequence s_cmp;
    compare_en_i && !flush_i && !select_source_i && !aux_control_r_i;
  endsequence
  sequence s_flush;
    flush_i && compare_en_i && !select_source_i && !aux_control_r_i;
  endsequence
  sequence s_tag_wr;
    tag_we_i && select_source_i && !flush_i && !aux_control_r_i;
  endsequence
  chk_tag_echo: assert property (
    s_tag_wr |-> ##2 tag_data_out_o == $past(compare_data_in_i, 2))
    else $error("written tag not shown");
  chk_flush_flags: assert property (
    s_flush |-> ##2 !access_permitted_o && !error_o)
    else $error("flush raised a compare flag");
  chk_miss_mmiss: assert property (
    s_cmp |-> ##2 !miss_o || modified_miss_o)
    else $error("miss without modified miss");
  chk_err_on_hit: assert property (
    error_o |-> !miss_o && !access_permitted_o)
    else $error("error without a clean hit");
  chk_aux_quiet: assert property (
    aux_control_r_i |-> ##2 !miss_o && !error_o && !access_permitted_o)
    else $error("suppressed cycle raised a flag");
  chk_idle_quiet: assert property (
    !compare_en_i && !flush_i |->
      ##2 !miss_o && !error_o && !access_permitted_o)
    else $error("flag without compare");
  chk_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule // tlb_cam_sram_props

bind tlb_cam_sram tlb_cam_sram_props u_tlb_cam_sram_props (.clk_i, .rst_i,
  .compare_data_in_i, .select_source_i, .compare_en_i, .flush_i, .tag_we_i,
  .aux_control_r_i, .tag_data_out_o, .miss_o, .error_o, .access_permitted_o,
  .modified_miss_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// *** sim/tlb_ctl.sv ***
// Behavioural translation controller driving the buffer's operation inputs.
// Assumes the bench calls one task at a time from a single process.
`timescale 1ns/1ps
`include "tlb_map.vh"
module tlb_ctl (
  input wire clk_i,
  output reg [`TLB_TAG_W-1:0] cd_o,
  output reg [`TLB_DATA_W-1:0] td_o,
  output reg [4:0] idx_o,
  output reg sel_o,
  output reg cen_o,
  output reg fl_o,
  output reg twe_o,
  output reg dwe_o,
  output reg aux_o,
  output reg [`TLB_PERM_W-1:0] perm_o
);
  // All controls start low so nothing happens before the first call.
  initial begin
    {cd_o, td_o, idx_o, sel_o, cen_o, fl_o, twe_o, dwe_o, aux_o, perm_o} = 0;
  end
  //////////////////////////////////////////////////////////////////////////
  // After capture go idle; compare, data and index buses flip so stale data cannot pass.
  task rest;
    @(posedge clk_i);
    {sel_o, cen_o, fl_o, twe_o, dwe_o, aux_o} <= 6'h0;
    cd_o <= ~cd_o;
    td_o <= ~td_o;
    idx_o <= ~idx_o;
    @(posedge clk_i);
    #1;
  endtask
  // Compare: select source stays low, criteria like a read.
  task cmp(input [`TLB_TAG_W-1:0] c, input [`TLB_PERM_W-1:0] p, input ax);
    @(posedge clk_i);
    cd_o <= c;
    perm_o <= p;
    aux_o <= ax;
    cen_o <= 1'b1;
    rest();
  endtask
  // Direct read of one entry.
  task dread(input [4:0] i);
    @(posedge clk_i);
    idx_o <= i;
    sel_o <= 1'b1;
    rest();
  endtask
  // Index goes out one cycle ahead of data and enables.
  task write(input [4:0] i, input [`TLB_TAG_W-1:0] t,
             input [`TLB_DATA_W-1:0] d, input tw, input dw);
    @(posedge clk_i);
    idx_o <= i;
    sel_o <= 1'b1;
    @(posedge clk_i);
    cd_o <= t;
    td_o <= d;
    twe_o <= tw;
    dwe_o <= dw;
    rest();
  endtask
  // Flush with source and write enables low; miss is never read after.
  task flush(input [`TLB_TAG_W-1:0] c);
    @(posedge clk_i);
    cd_o <= c;
    cen_o <= 1'b1;
    fl_o <= 1'b1;
    rest();
  endtask
endmodule // tlb_ctl

// *** sim/tb.sv ***
// Self-checking bench for the translation buffer and its register block.
// Assumes the controller model and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "tlb_map.vh"
module tb;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [3:0] wb_adr_i = 4'h0;
  reg [3:0] wb_sel_i = 4'h0;
  reg [3:0] wsel = 4'hf;
  reg [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq_o, miss_o, error_o, acc_o, mmiss_o;
  wire sel, cen, fl, twe, dwe, aux;
  wire [40:0] cd, tag_o;
  wire [27:0] td, dat_o;
  wire [4:0] idx;
  wire [5:0] perm;
  integer fails = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer k;
  reg [15:0] seed = 16'h36a2;
  reg [40:0] tags [0:3];
  reg [27:0] dats [0:3];
  reg [4:0] ix [0:3];
  reg [40:0] c;
  reg [31:0] q;
  reg [5:0] req;
  always #4 clk_i = ~clk_i;
  tlb_ctl u_tlb_ctl (.clk_i, .cd_o(cd), .td_o(td), .idx_o(idx), .sel_o(sel),
    .cen_o(cen), .fl_o(fl), .twe_o(twe), .dwe_o(dwe), .aux_o(aux),
    .perm_o(perm));
  tlb_cam_sram u_tlb_cam_sram (.clk_i, .rst_i, .compare_data_in_i(cd),
    .translation_data_in_i(td), .entry_index_i(idx), .select_source_i(sel),
    .compare_en_i(cen), .flush_i(fl), .tag_we_i(twe), .data_we_i(dwe),
    .aux_control_r_i(aux), .req_perm_i(perm), .tag_data_out_o(tag_o),
    .translation_data_out_o(dat_o), .miss_o, .error_o,
    .access_permitted_o(acc_o), .modified_miss_o(mmiss_o), .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .irq_o);
  //////////////////////////////////////////////////////////////////////////
  // Random source and expectation helpers.
  function [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    rnd = seed;
  endfunction
  // Valid tag, random modified bit, supervisor write withheld, unique low bits.
  function [40:0] mk(input [1:0] n);
    reg [15:0] a;
    reg [15:0] b;
    a = rnd();
    b = rnd();
    mk = {1'b1, a[15], a[5:1], 1'b0, 3'h0, b, a[14:6], 3'h0, n};
  endfunction
  function ee(input [40:0] t, input [5:0] r);
    ee = |(~t[`TLB_PERM_HI:`TLB_PERM_LO] & r);
  endfunction
  function mok(input [40:0] t, input [5:0] r);
    mok = t[`TLB_MOD_BIT] || !(r[`TLB_USER_WRITE_PERM] ||
      r[`TLB_SUPER_WRITE_PERM]);
  endfunction
  task chk_val(input string n, input [40:0] e, input [40:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Classic single cycle; the request holds until ack is sampled high.
  task wb(input we, input [3:0] a, input [31:0] d, output [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= wsel;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task tally_and_finish;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // A hang costs a mismatch; the whole run needs well under this.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Main sequence; arrays power up unknown, so flush all first.
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    c = 41'h0;
    c[`TLB_LVL_HI:`TLB_LVL_LO] = `TLB_LVL_ALL;
    u_tlb_ctl.flush(c);
    wb(1'b0, `TLB_REG_STATE, 32'h0, q);
    chk_val("count", 0, q[5:0]);
    wb(1'b1, `TLB_REG_IRQ_MASK, 32'h1, q);
    {ix[0], ix[1], ix[2], ix[3]} = {5'h00, 5'h1f, 5'h05, 5'h11};
    for (k = 0; k < 4; k = k + 1) begin
      tags[k] = mk(k[1:0]);
      q = {rnd(), rnd()};
      dats[k] = q[27:0];
      u_tlb_ctl.write(ix[k], tags[k], dats[k], 1'b1, 1'b1);
    end
    tags[0] = mk(2'd0);
    u_tlb_ctl.write(ix[0], tags[0], ~dats[0], 1'b1, 1'b0);
    dats[1] = ~dats[1];
    u_tlb_ctl.write(ix[1], ~tags[1], dats[1], 1'b0, 1'b1);
    wb(1'b0, `TLB_REG_STATE, 32'h0, q);
    chk_val("count", 4, q[5:0]);
    for (k = 0; k < 4; k = k + 1) begin
      u_tlb_ctl.dread(ix[k]);
      chk_val("tag", tags[k], tag_o);
      chk_val("data", dats[k], dat_o);
      q = rnd();
      req = (k == 0) ? 6'h3f : q[5:0];
      u_tlb_ctl.cmp(tags[k], req, 1'b0);
      chk_val("miss", 0, miss_o);
      chk_val("hit data", dats[k], dat_o);
      chk_val("error", ee(tags[k], req), error_o);
      chk_val("acc", !ee(tags[k], req) && mok(tags[k], req), acc_o);
      chk_val("mmiss", !mok(tags[k], req), mmiss_o);
    end
    // Miss raises the interrupt; clear, then mask.
    c = tags[0];
    c[4:0] = 5'h1f;
    u_tlb_ctl.cmp(c, 6'h0, 1'b0);
    chk_val("miss", 1, miss_o);
    chk_val("acc", 0, acc_o);
    wb(1'b0, `TLB_REG_IRQ_STAT, 32'h0, q);
    chk_val("status", 1, q[0]);
    chk_val("irq", 1, irq_o);
    wb(1'b1, `TLB_REG_IRQ_STAT, 32'h1, q);
    wb(1'b1, `TLB_REG_IRQ_MASK, 32'h0, q);
    chk_val("irq", 0, irq_o);
    u_tlb_ctl.cmp(c, 6'h0, 1'b0);
    wb(1'b0, `TLB_REG_IRQ_STAT, 32'h0, q);
    chk_val("status", 1, q[0]);
    chk_val("irq", 0, irq_o);
    wb(1'b0, 4'hc, 32'h0, q);
    chk_val("unmapped", 0, q);
    // A write whose low byte lane is not selected must leave the mask alone.
    wsel = 4'h0;
    wb(1'b1, `TLB_REG_IRQ_MASK, 32'h1, q);
    wsel = 4'hf;
    wb(1'b0, `TLB_REG_IRQ_MASK, 32'h0, q);
    chk_val("mask", 0, q);
    u_tlb_ctl.cmp(tags[1], 6'h0, 1'b1);
    chk_val("acc", 0, acc_o);
    // Single-entry flush: only its valid bit goes.
    u_tlb_ctl.flush(tags[2]);
    u_tlb_ctl.cmp(tags[2], 6'h0, 1'b0);
    chk_val("miss", 1, miss_o);
    u_tlb_ctl.dread(ix[2]);
    c = tags[2];
    c[`TLB_VALID_BIT] = 1'b0;
    chk_val("tag", c, tag_o);
    chk_val("data", dats[2], dat_o);
    u_tlb_ctl.cmp(tags[3], 6'h0, 1'b0);
    chk_val("miss", 0, miss_o);
    c = tags[0];
    c[4:0] = 5'h1f;
    u_tlb_ctl.flush(c);
    wb(1'b0, `TLB_REG_STATE, 32'h0, q);
    chk_val("count", 3, q[5:0]);
    c = 41'h0;
    c[`TLB_LVL_HI:`TLB_LVL_LO] = `TLB_LVL_ALL;
    u_tlb_ctl.flush(c);
    wb(1'b0, `TLB_REG_STATE, 32'h0, q);
    chk_val("count", 0, q[5:0]);
    tally_and_finish();
  end
endmodule // tb
